// ---- rtl/hspc_consts.svh ----
`ifndef HSPC_CONSTS_SVH
`define HSPC_CONSTS_SVH

// ****************************************************************
// Register indices; the byte address on the bus is four times each.
// ****************************************************************
`define HSPC_IDX_T0_CONTROL    16'hFE10
`define HSPC_IDX_T0_COUNT_LO   16'hFE12
`define HSPC_IDX_T0_COUNT_HI   16'hFE13
`define HSPC_IDX_T0_MATCH_LO   16'hFE14
`define HSPC_IDX_T0_MATCH_HI   16'hFE15
`define HSPC_IDX_T0_CAPT_LO    16'hFE16
`define HSPC_IDX_T0_CAPT_HI    16'hFE17
`define HSPC_IDX_P1_TEST       16'hFE47
`define HSPC_IDX_INT01         16'hFE5D
`define HSPC_IDX_INT23         16'hFE5E
`define HSPC_IDX_INPUT_SEL     16'hFE5F
`define HSPC_IDX_PC_CONTROL    16'hFE7D

// ****************************************************************
// Field positions.
// ****************************************************************
`define HSPC_T0_HIGH_RUN       7
`define HSPC_T0_LOW_RUN        6
`define HSPC_T0_16BIT_SEL      5
`define HSPC_T0_LOW_EXT_SEL    4
`define HSPC_T0_HIGH_FLAG      3
`define HSPC_T0_HIGH_IE        2
`define HSPC_T0_LOW_FLAG       1
`define HSPC_T0_LOW_IE         0
`define HSPC_PC_ENABLE         7
`define HSPC_PC_CMP_MSB        6
`define HSPC_PC_CMP_LSB        4
`define HSPC_P1_RT_DISABLE     2

// ****************************************************************
// Reset values and fixed figures.
// ****************************************************************
`define HSPC_RESET_BYTE        8'h00
`define HSPC_RESET_FINE        3'h0
`define HSPC_MATCH_OFFSET      20'h00010
`define HSPC_MATCH_OFFSET_11   12'h010
`define HSPC_BYTE_FULL         8'hFF
`define HSPC_FINE_FULL         3'h7

`endif

// ---- rtl/hspc_pkg.sv ----
package hspc_pkg;

   typedef logic [7:0] hspc_byte_type;

   typedef enum logic [1:0] {
      HSPC_MODE_PLAIN,
      HSPC_MODE_11BIT,
      HSPC_MODE_19BIT
   } hspc_mode_type;

endpackage : hspc_pkg

// ---- rtl/hspc_sync.sv ----
`timescale 1ns/1ps

module hspc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule : hspc_sync

// ---- rtl/hspc_fine_counter.sv ----
`timescale 1ns/1ps
`include "hspc_consts.svh"

module hspc_fine_counter (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Control
   input  wire logic       clear,
   input  wire logic       advance,
   // State
   output logic [2:0]      count,
   output logic            wrap
);

   assign wrap = advance && !clear && (count == `HSPC_FINE_FULL);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= `HSPC_RESET_FINE;
      end else if (clear) begin
         count <= `HSPC_RESET_FINE;
      end else if (advance) begin
         count <= count + 3'h1;
      end
   end

endmodule : hspc_fine_counter

// ---- rtl/hspc_top.sv ----
`timescale 1ns/1ps
`include "hspc_consts.svh"

module hspc_top (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RESETN,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Pins
   input  wire logic        PULSE_COUNT_INPUT,
   input  wire logic        TIMER0_EXTERNAL_INPUT,
   input  wire logic        TIMER0_CAPTURE_INPUT,
   // Same-clock inputs from the timer 0 prescaler and the port 1 latch
   input  wire logic        TIMER0_PRESCALE_TICK,
   input  wire logic        PORT_LATCH_DATA,
   // Outputs
   output logic             REALTIME_OUTPUT_PIN,
   output logic             TIMER0_LOW_IRQ,
   output logic             TIMER0_HIGH_IRQ
);

   // ****************************************************************
   // Registers and state.
   // ****************************************************************
   hspc_pkg::hspc_byte_type timer0_control;
   hspc_pkg::hspc_byte_type timer0_count_low;
   hspc_pkg::hspc_byte_type timer0_count_high;
   hspc_pkg::hspc_byte_type timer0_match_low;
   hspc_pkg::hspc_byte_type timer0_match_high;
   hspc_pkg::hspc_byte_type timer0_capture_low;
   hspc_pkg::hspc_byte_type timer0_capture_high;
   hspc_pkg::hspc_byte_type ext_int01_control;
   hspc_pkg::hspc_byte_type ext_int23_control;
   hspc_pkg::hspc_byte_type input_select;
   logic                    counter_enable;
   logic [2:0]              fine_compare_field;
   logic                    capture_carry;
   logic [2:0]              fine_capture_field;
   logic                    realtime_output_disable;
   logic                    armed;

   // ****************************************************************
   // Pin synchronisers and edge detection.
   // ****************************************************************
   logic [2:0] pin_sync;
   logic [2:0] pin_last;
   logic [2:0] pin_rise;

   hspc_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk    (CLK),
      .resetn (RESETN),
      .d      ({TIMER0_CAPTURE_INPUT, TIMER0_EXTERNAL_INPUT, PULSE_COUNT_INPUT}),
      .q      (pin_sync)
   );

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pin_last <= 3'h0;
      end else begin
         pin_last <= pin_sync;
      end
   end

   assign pin_rise = pin_sync & ~pin_last;

   // ****************************************************************
   // Mode and counting.
   // ****************************************************************
   logic                  low_run;
   logic                  high_run;
   logic                  long_sel;
   hspc_pkg::hspc_mode_type mode;
   logic [2:0]            fine_count;
   logic                  fine_wrap;
   logic                  low_tick;
   logic                  low_full;
   logic                  high_tick;
   logic                  plain_low_match;
   logic                  plain_high_match;
   logic                  hs_match;
   logic [11:0]           target11;
   logic [19:0]           target19;

   assign low_run  = timer0_control[`HSPC_T0_LOW_RUN];
   assign high_run = timer0_control[`HSPC_T0_HIGH_RUN];
   assign long_sel = timer0_control[`HSPC_T0_16BIT_SEL];

   always_comb begin
      if (!counter_enable) begin
         mode = hspc_pkg::HSPC_MODE_PLAIN;
      end else if (long_sel) begin
         mode = hspc_pkg::HSPC_MODE_19BIT;
      end else begin
         mode = hspc_pkg::HSPC_MODE_11BIT;
      end
   end

   hspc_fine_counter u_fine (
      .clk     (CLK),
      .resetn  (RESETN),
      .clear   (!counter_enable || !low_run),
      .advance (pin_rise[0]),
      .count   (fine_count),
      .wrap    (fine_wrap)
   );

   assign low_tick = counter_enable ? fine_wrap
                   : (timer0_control[`HSPC_T0_LOW_EXT_SEL] ? pin_rise[1] : TIMER0_PRESCALE_TICK);
   assign low_full = (timer0_count_low == `HSPC_BYTE_FULL);

   // Plain timer 0 matches clear the count; in 16-bit mode all sixteen bits must agree.
   assign plain_low_match  = (mode == hspc_pkg::HSPC_MODE_PLAIN) && low_run && low_tick
                           && (timer0_count_low == timer0_match_low)
                           && (!long_sel || timer0_count_high == timer0_match_high);
   assign plain_high_match = long_sel ? plain_low_match
                           : (high_run && TIMER0_PRESCALE_TICK && (mode != hspc_pkg::HSPC_MODE_19BIT)
                              && (timer0_count_high == timer0_match_high));

   always_comb begin
      unique case (mode)
         hspc_pkg::HSPC_MODE_19BIT: high_tick = low_tick && low_full;
         hspc_pkg::HSPC_MODE_11BIT: high_tick = TIMER0_PRESCALE_TICK;
         hspc_pkg::HSPC_MODE_PLAIN: high_tick = long_sel ? (low_tick && low_full)
                                                         : TIMER0_PRESCALE_TICK;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         timer0_count_low <= `HSPC_RESET_BYTE;
      end else if (!low_run) begin
         timer0_count_low <= `HSPC_RESET_BYTE;
      end else if (plain_low_match) begin
         timer0_count_low <= `HSPC_RESET_BYTE;
      end else if (low_tick) begin
         timer0_count_low <= timer0_count_low + 8'h01;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         timer0_count_high <= `HSPC_RESET_BYTE;
      end else if (!high_run) begin
         timer0_count_high <= `HSPC_RESET_BYTE;
      end else if (plain_high_match) begin
         timer0_count_high <= `HSPC_RESET_BYTE;
      end else if (high_tick) begin
         timer0_count_high <= timer0_count_high + 8'h01;
      end
   end

   // ****************************************************************
   // High-speed match detection.
   // ****************************************************************
   // The 11-bit target keeps a spare top bit so a target past 2047 never matches.
   assign target11 = {1'b0, timer0_match_low, fine_compare_field} + `HSPC_MATCH_OFFSET_11;
   assign target19 = {1'b0, timer0_match_high, timer0_match_low, fine_compare_field}
                   + `HSPC_MATCH_OFFSET;

   always_comb begin
      unique case (mode)
         hspc_pkg::HSPC_MODE_11BIT:
            hs_match = armed && low_run && ({1'b0, timer0_count_low, fine_count} == target11);
         hspc_pkg::HSPC_MODE_19BIT:
            hs_match = armed && low_run
                     && ({1'b0, timer0_count_high, timer0_count_low, fine_count} == target19);
         hspc_pkg::HSPC_MODE_PLAIN:
            hs_match = 1'b0;
      endcase
   end

   // ****************************************************************
   // AHB-Lite slave.
   // ****************************************************************
   logic        wr_pending;
   logic [15:0] wr_index;
   logic        addr_ok;
   logic [15:0] addr_index;
   logic [7:0]  wbyte;
   logic        wr_t0ctl;
   logic        wr_pcctl;

   assign addr_index = HADDR[17:2];
   assign addr_ok    = HSEL && HREADY && HTRANS[1] && (HADDR[31:18] == 14'h0000);
   assign wbyte      = HWDATA[7:0];
   assign wr_t0ctl   = wr_pending && (wr_index == `HSPC_IDX_T0_CONTROL);
   assign wr_pcctl   = wr_pending && (wr_index == `HSPC_IDX_PC_CONTROL);

   function automatic logic [7:0] read_mux(input logic [15:0] idx);
      unique case (idx)
         `HSPC_IDX_T0_CONTROL:  read_mux = timer0_control;
         `HSPC_IDX_T0_COUNT_LO: read_mux = timer0_count_low;
         `HSPC_IDX_T0_COUNT_HI: read_mux = timer0_count_high;
         `HSPC_IDX_T0_MATCH_LO: read_mux = timer0_match_low;
         `HSPC_IDX_T0_MATCH_HI: read_mux = timer0_match_high;
         `HSPC_IDX_T0_CAPT_LO:  read_mux = timer0_capture_low;
         `HSPC_IDX_T0_CAPT_HI:  read_mux = timer0_capture_high;
         `HSPC_IDX_P1_TEST:     read_mux = {5'h00, realtime_output_disable, 2'h0};
         `HSPC_IDX_INT01:       read_mux = ext_int01_control;
         `HSPC_IDX_INT23:       read_mux = ext_int23_control;
         `HSPC_IDX_INPUT_SEL:   read_mux = input_select;
         `HSPC_IDX_PC_CONTROL:  read_mux = {counter_enable, fine_compare_field,
                                           capture_carry, fine_capture_field};
         default:               read_mux = 8'h00;
      endcase
   endfunction : read_mux

   // Read data is sampled at the address phase so HRDATA can come from a flop
   // with no wait state; a read right behind a write sees the old value.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_pending <= 1'b0;
         wr_index   <= 16'h0000;
         HRDATA     <= 32'h00000000;
      end else begin
         wr_pending <= addr_ok && HWRITE;
         wr_index   <= addr_index;
         if (addr_ok && !HWRITE) begin
            HRDATA <= {24'h000000, read_mux(addr_index)};
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // ****************************************************************
   // Software-written registers.
   // ****************************************************************
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         timer0_match_low        <= `HSPC_RESET_BYTE;
         timer0_match_high       <= `HSPC_RESET_BYTE;
         ext_int01_control       <= `HSPC_RESET_BYTE;
         ext_int23_control       <= `HSPC_RESET_BYTE;
         input_select            <= `HSPC_RESET_BYTE;
         realtime_output_disable <= 1'b0;
         counter_enable          <= 1'b0;
         fine_compare_field      <= `HSPC_RESET_FINE;
      end else if (wr_pending) begin
         unique case (wr_index)
            `HSPC_IDX_T0_MATCH_LO: timer0_match_low  <= wbyte;
            `HSPC_IDX_T0_MATCH_HI: timer0_match_high <= wbyte;
            `HSPC_IDX_INT01:       ext_int01_control <= wbyte;
            `HSPC_IDX_INT23:       ext_int23_control <= wbyte;
            `HSPC_IDX_INPUT_SEL:   input_select      <= wbyte;
            `HSPC_IDX_P1_TEST:     realtime_output_disable <= wbyte[`HSPC_P1_RT_DISABLE];
            `HSPC_IDX_PC_CONTROL: begin
               counter_enable     <= wbyte[`HSPC_PC_ENABLE];
               fine_compare_field <= wbyte[`HSPC_PC_CMP_MSB:`HSPC_PC_CMP_LSB];
            end
            default: ;
         endcase
      end
   end

   // Match flags are set by hardware; a set in the same cycle as a clear wins.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         timer0_control <= `HSPC_RESET_BYTE;
      end else begin
         if (wr_t0ctl) begin
            timer0_control <= wbyte;
         end
         if (plain_low_match || hs_match) begin
            timer0_control[`HSPC_T0_LOW_FLAG] <= 1'b1;
         end
         if (plain_high_match || (hs_match && long_sel)) begin
            timer0_control[`HSPC_T0_HIGH_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         armed <= 1'b0;
      end else if (wr_pcctl) begin
         armed <= wbyte[`HSPC_PC_ENABLE];
      end else if (hs_match) begin
         armed <= 1'b0;
      end
   end

   // ****************************************************************
   // Capture.
   // ****************************************************************
   // fine count and carry capture
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         timer0_capture_low  <= `HSPC_RESET_BYTE;
         timer0_capture_high <= `HSPC_RESET_BYTE;
         capture_carry       <= 1'b0;
         fine_capture_field  <= `HSPC_RESET_FINE;
      end else if (pin_rise[2]) begin
         timer0_capture_low  <= timer0_count_low;
         timer0_capture_high <= timer0_count_high;
         capture_carry       <= fine_wrap;
         fine_capture_field  <= fine_count;
      end
   end

   // ****************************************************************
   // Realtime output and interrupt requests.
   // ****************************************************************
   // fall back to the port latch
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         REALTIME_OUTPUT_PIN <= 1'b0;
      end else if (counter_enable && armed && !realtime_output_disable && !hs_match) begin
         REALTIME_OUTPUT_PIN <= REALTIME_OUTPUT_PIN;
      end else begin
         REALTIME_OUTPUT_PIN <= PORT_LATCH_DATA;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         TIMER0_LOW_IRQ  <= 1'b0;
         TIMER0_HIGH_IRQ <= 1'b0;
      end else begin
         TIMER0_LOW_IRQ  <= timer0_control[`HSPC_T0_LOW_FLAG] && timer0_control[`HSPC_T0_LOW_IE];
         TIMER0_HIGH_IRQ <= timer0_control[`HSPC_T0_HIGH_FLAG]
                         && timer0_control[`HSPC_T0_HIGH_IE];
      end
   end

endmodule : hspc_top

// ---- tb/hspc_top_assertions.sv ----
`timescale 1ns/1ps
`include "hspc_consts.svh"

module hspc_top_assertions (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        RESETN,
   // Bus
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   // Pins
   input wire logic        PORT_LATCH_DATA,
   input wire logic        REALTIME_OUTPUT_PIN,
   input wire logic        TIMER0_LOW_IRQ,
   input wire logic        TIMER0_HIGH_IRQ
);
   logic        wr;
   logic        rd;
   logic        unm;
   logic [15:0] idx;
   logic        en;
   logic        dis;
   logic [1:0]  ie;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr  <= 1'b0;
         rd  <= 1'b0;
         unm <= 1'b0;
         idx <= 16'h0000;
      end else begin
         wr  <= HSEL & HREADY & HTRANS[1] & HWRITE;
         rd  <= HSEL & HREADY & HTRANS[1] & !HWRITE;
         idx <= HADDR[17:2];
         unm <= !(HADDR[17:2] inside {`HSPC_IDX_T0_CONTROL, `HSPC_IDX_T0_COUNT_LO,
            `HSPC_IDX_T0_COUNT_HI, `HSPC_IDX_T0_MATCH_LO, `HSPC_IDX_T0_MATCH_HI,
            `HSPC_IDX_T0_CAPT_LO, `HSPC_IDX_T0_CAPT_HI, `HSPC_IDX_P1_TEST,
            `HSPC_IDX_INT01, `HSPC_IDX_INT23, `HSPC_IDX_INPUT_SEL, `HSPC_IDX_PC_CONTROL});
      end
   end

   // Mirrors of the control bits, updated at the same edge as the design's own copies.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         en  <= 1'b0;
         dis <= 1'b0;
         ie  <= 2'h0;
      end else if (wr) begin
         if (idx == `HSPC_IDX_PC_CONTROL) en <= HWDATA[`HSPC_PC_ENABLE];
         if (idx == `HSPC_IDX_P1_TEST) dis <= HWDATA[`HSPC_P1_RT_DISABLE];
         if (idx == `HSPC_IDX_T0_CONTROL) ie <= {HWDATA[`HSPC_T0_HIGH_IE], HWDATA[`HSPC_T0_LOW_IE]};
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   sequence s_held(x);
      x ##1 x;
   endsequence

   a_ready_always: assert property (HREADYOUT == 1'b1) else $error("ready low");
   a_resp_okay: assert property (HRESP == 1'b0) else $error("response not okay");
   a_rdata_upper: assert property (HRDATA[31:8] == 24'h000000) else $error("upper data set");
   a_rdata_holds: assert property (!rd |-> $stable(HRDATA)) else $error("read data moved");
   a_unmapped_zero: assert property (rd && unm |-> HRDATA == 32'h0) else $error("unmapped read");
   a_pin_follows_latch: assert property (
      s_held(dis || !en) |-> REALTIME_OUTPUT_PIN == $past(PORT_LATCH_DATA) || !$past(RESETN))
      else $error("pin not following latch");
   a_low_irq_rise: assert property (
      $rose(TIMER0_LOW_IRQ) |-> $past(ie[0])) else $error("low request without enable");
   a_low_irq_quiet: assert property (
      s_held(!ie[0]) |-> !TIMER0_LOW_IRQ) else $error("low request while masked");
   a_high_irq_quiet: assert property (
      s_held(!ie[1]) |-> !TIMER0_HIGH_IRQ) else $error("high request while masked");
endmodule : hspc_top_assertions

bind hspc_top hspc_top_assertions u_chk (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PORT_LATCH_DATA(PORT_LATCH_DATA),
   .REALTIME_OUTPUT_PIN(REALTIME_OUTPUT_PIN), .TIMER0_LOW_IRQ(TIMER0_LOW_IRQ),
   .TIMER0_HIGH_IRQ(TIMER0_HIGH_IRQ));

// ---- tb/hspc_pulse_source.sv ----
`timescale 1ns/1ps

module hspc_pulse_source (
   // Clock
   input  wire logic clk,
   // Pins
   output logic      pulse,
   output logic      capture
);
   initial begin
      pulse   = 1'b0;
      capture = 1'b0;
   end

   // each level stands three clocks, so the synchroniser never misses one.
   task automatic send(input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge clk);
         pulse <= ~pulse;
         repeat (2) @(posedge clk);
      end
   endtask : send

   task automatic snap();
      @(posedge clk);
      capture <= 1'b1;
      repeat (3) @(posedge clk);
      capture <= 1'b0;
   endtask : snap
endmodule : hspc_pulse_source

// ---- tb/test_high_speed_pulse_counter.sv ----
`timescale 1ns/1ps
`include "hspc_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module test_high_speed_pulse_counter;
   logic        clk;
   logic        resetn;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        pulse;
   logic        capture;
   logic        latch;
   logic        pin;
   logic        irq_lo;
   logic        irq_hi;
   logic        hsel;
   logic [2:0]  hsize;
   logic        hresp;
   logic        timer0_low_external_clock_select;
   logic        tick;
   logic [31:0] rd;
   int          bad_count = 0;
   int          checked = 0;
   int          cycles = 0;

   hspc_top u_dut (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .PULSE_COUNT_INPUT(pulse),
      .TIMER0_EXTERNAL_INPUT(timer0_low_external_clock_select), .TIMER0_CAPTURE_INPUT(capture),
      .TIMER0_PRESCALE_TICK(tick), .PORT_LATCH_DATA(latch),
      .REALTIME_OUTPUT_PIN(pin), .TIMER0_LOW_IRQ(irq_lo), .TIMER0_HIGH_IRQ(irq_hi));
   hspc_pulse_source u_src (.clk(clk), .pulse(pulse), .capture(capture));

   task automatic stop_test();
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hsize  <= 3'h2;
      hwrite <= w;
      haddr  <= {14'h0000, i, 2'h0};
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic expect_reg(input logic [15:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      `CHK(rd, {24'h000000, e})
      `CHK(hresp, 1'b0)
   endtask : expect_reg

   task automatic t_reset();
      expect_reg(`HSPC_IDX_T0_CONTROL, 8'h00);
      expect_reg(`HSPC_IDX_PC_CONTROL, 8'h00);
      expect_reg(`HSPC_IDX_T0_MATCH_HI, 8'h00);
      bus(1'b1, `HSPC_IDX_T0_COUNT_LO, 8'h5A);
      expect_reg(`HSPC_IDX_T0_COUNT_LO, 8'h00);
      bus(1'b1, 16'hFE00, 8'hA5);
      expect_reg(16'hFE00, 8'h00);
   endtask : t_reset

   task automatic t_match();
      bus(1'b1, `HSPC_IDX_T0_CONTROL, 8'h51);
      bus(1'b1, `HSPC_IDX_T0_MATCH_LO, 8'h00);
      bus(1'b1, `HSPC_IDX_PC_CONTROL, 8'hB0);
      latch <= 1'b1;
      u_src.send(18);
      repeat (6) @(negedge clk);
      `CHK(pin, 1'b0)
      `CHK(irq_lo, 1'b0)
      u_src.send(1);
      repeat (6) @(negedge clk);
      `CHK(pin, 1'b1)
      `CHK(irq_lo, 1'b1)
      `CHK(irq_hi, 1'b0)
      expect_reg(`HSPC_IDX_T0_CONTROL, 8'h53);
      expect_reg(`HSPC_IDX_T0_COUNT_LO, 8'h02);
   endtask : t_match

   task automatic t_after();
      latch <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK(pin, 1'b0)
      bus(1'b1, `HSPC_IDX_T0_CONTROL, 8'h51);
      expect_reg(`HSPC_IDX_T0_CONTROL, 8'h51);
      u_src.send(8);
      repeat (6) @(negedge clk);
      expect_reg(`HSPC_IDX_T0_CONTROL, 8'h51);
      u_src.snap();
      repeat (6) @(negedge clk);
      expect_reg(`HSPC_IDX_T0_CAPT_LO, 8'h03);
      expect_reg(`HSPC_IDX_PC_CONTROL, 8'hB3);
   endtask : t_after

   task automatic t_run();
      bus(1'b1, `HSPC_IDX_T0_CONTROL, 8'h11);
      u_src.send(3);
      repeat (6) @(negedge clk);
      expect_reg(`HSPC_IDX_T0_COUNT_LO, 8'h00);
      bus(1'b1, `HSPC_IDX_T0_CONTROL, 8'h51);
      u_src.send(9);
      repeat (6) @(negedge clk);
      expect_reg(`HSPC_IDX_T0_COUNT_LO, 8'h01);
      u_src.snap();
      repeat (6) @(negedge clk);
      expect_reg(`HSPC_IDX_PC_CONTROL, 8'hB1);
   endtask : t_run

   // disabled output is a plain port.
   task automatic t_plain();
      bus(1'b1, `HSPC_IDX_P1_TEST, 8'hFF);
      expect_reg(`HSPC_IDX_P1_TEST, 8'h04);
      bus(1'b1, `HSPC_IDX_PC_CONTROL, 8'hB0);
      latch <= 1'b1;
      repeat (3) @(negedge clk);
      `CHK(pin, 1'b1)
   endtask : t_plain

   // nineteen-bit mode sets both flags at one match.
   task automatic t_long();
      latch <= 1'b0;
      bus(1'b1, `HSPC_IDX_T0_CONTROL, 8'h00);
      bus(1'b1, `HSPC_IDX_P1_TEST, 8'h00);
      bus(1'b1, `HSPC_IDX_T0_CONTROL, 8'hF5);
      bus(1'b1, `HSPC_IDX_PC_CONTROL, 8'hB0);
      latch <= 1'b1;
      repeat (3) @(negedge clk);
      `CHK(pin, 1'b0)
      u_src.send(19);
      repeat (6) @(negedge clk);
      `CHK(pin, 1'b1)
      `CHK(irq_hi, 1'b1)
      `CHK(irq_lo, 1'b1)
      expect_reg(`HSPC_IDX_T0_CONTROL, 8'hFF);
      expect_reg(`HSPC_IDX_T0_COUNT_HI, 8'h00);
      expect_reg(`HSPC_IDX_T0_COUNT_LO, 8'h02);
   endtask : t_long

   // with the counter off, timer 0 low counts only its own clock.
   task automatic t_free();
      bus(1'b1, `HSPC_IDX_PC_CONTROL, 8'h00);
      latch <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK(pin, 1'b0)
      bus(1'b1, `HSPC_IDX_T0_CONTROL, 8'h00);
      bus(1'b1, `HSPC_IDX_T0_MATCH_LO, 8'h02);
      bus(1'b1, `HSPC_IDX_T0_CONTROL, 8'h50);
      u_src.send(8);
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         timer0_low_external_clock_select <= ~timer0_low_external_clock_select;
         repeat (2) @(posedge clk);
      end
      repeat (6) @(negedge clk);
      expect_reg(`HSPC_IDX_T0_CONTROL, 8'h52);
      expect_reg(`HSPC_IDX_T0_COUNT_LO, 8'h00);
      `CHK(irq_lo, 1'b0)
   endtask : t_free

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // The whole run needs about six hundred cycles; twenty thousand marks a hang.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      resetn = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      hsel   = 1'b0;
      hsize  = 3'h0;
      timer0_low_external_clock_select  = 1'b0;
      tick   = 1'b0;
      latch  = 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_match();
      t_after();
      t_run();
      t_plain();
      t_long();
      t_free();
      stop_test();
   end
endmodule : test_high_speed_pulse_counter
